/* aph_pkg.sv */
// Notes on behaviour
// - While the automation reset input is low the sequencer is held in reset; high lets it run.
// - A run begins when the start request goes high.
// - The in-progress output is high for the whole of a run.
// - Pass goes high and stays high when the read-back check finds the target correct.
// - Pass clears to low when a new start request arrives.
// - Pass toggles high and low as a progress sign while erase, program and verify run.
// - Fail goes high when the read-back check finds a mismatch.
// - Fail clears to low when a new start request arrives.
// - Fail toggles high and low when the target cannot be reached.
// - The automation port only starts runs and reports status, never loads the image store.
// - Each run is a mass erase, then programming of the stored image, then read-back check.
// - In-progress returns low once the check has completed.
// - A target that does not answer at the start keeps in-progress low and raises fail at once.
package aph_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned START_PULSE_MS = 200;
   // least pulse in whole cycles; CLK_HZ / 1000 truncates, no rounding up
   localparam int unsigned START_PULSE_CYC = (START_PULSE_MS * (CLK_HZ / 1000));
   localparam int unsigned BLINK_MS = 250;
   localparam int unsigned BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
   localparam int unsigned CNT_W = 24;

   typedef enum logic [4:0] {
      APH_IDLE = 5'h01,
      APH_ERASE = 5'h02,
      APH_PROG = 5'h04,
      APH_VERIFY = 5'h08,
      APH_DONE = 5'h10
   } aph_state_e;
endpackage : aph_pkg

/* aph_seq.sv */
`timescale 1ns/1ps
module aph_seq #(
   parameter int unsigned BLINK_CYCLES = aph_pkg::BLINK_CYC
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_automation_reset_n,
   input wire logic i_start_req,
   input wire logic i_tgt_ack,
   input wire logic i_erase_done,
   input wire logic i_prog_done,
   input wire logic i_verify_done,
   input wire logic i_verify_ok,
   output logic o_erase_go,
   output logic o_prog_go,
   output logic o_verify_go,
   output logic o_in_progress,
   output logic o_pass,
   output logic o_fail,
   output logic o_cpu_rstn
);
   import aph_pkg::*;

   // refused at elaboration: the timebase counter cannot reach larger counts
   if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (1 << CNT_W)) begin : g_bad_blink
      $error("BLINK_CYCLES out of range");
   end

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers; the first stage feeds only the second
   logic rst_meta_ff, rst_sync_ff;
   logic req_meta_ff, req_sync_ff, req_prev_ff;
   logic ack_meta_ff, ack_sync_ff;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= i_automation_reset_n;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         req_meta_ff <= 1'b0;
         req_sync_ff <= 1'b0;
         req_prev_ff <= 1'b0;
         ack_meta_ff <= 1'b0;
         ack_sync_ff <= 1'b0;
      end else begin
         req_meta_ff <= i_start_req;
         req_sync_ff <= req_meta_ff;
         req_prev_ff <= req_sync_ff;
         ack_meta_ff <= i_tgt_ack;
         ack_sync_ff <= ack_meta_ff;
      end
   end

   logic run_ok;
   logic start_edge;
   assign run_ok = rst_sync_ff;
   assign start_edge = req_sync_ff & ~req_prev_ff;
   assign o_cpu_rstn = rst_sync_ff;

   ////////////////////////////////////////////////////////////////////
   // sequencer; no path here writes the image store
   aph_state_e state_ff;
   aph_state_e nxt_state;
   logic nxt_fail_solid, nxt_fail_blink, nxt_pass_solid;
   logic fail_solid_ff, fail_blink_ff, pass_solid_ff;

   always_comb begin
      nxt_state = state_ff;
      nxt_fail_solid = fail_solid_ff;
      nxt_fail_blink = fail_blink_ff;
      nxt_pass_solid = pass_solid_ff;
      unique case (state_ff)
         APH_IDLE, APH_DONE: begin
            if (start_edge) begin
               nxt_pass_solid = 1'b0;
               nxt_fail_solid = 1'b0;
               nxt_fail_blink = 1'b0;
               if (ack_sync_ff) begin
                  nxt_state = APH_ERASE;
               end else begin
                  nxt_fail_blink = 1'b1;
                  nxt_state = APH_DONE;
               end
            end
         end
         APH_ERASE: begin
            if (i_erase_done) begin
               nxt_state = APH_PROG;
            end
         end
         APH_PROG: begin
            if (i_prog_done) begin
               nxt_state = APH_VERIFY;
            end
         end
         APH_VERIFY: begin
            if (i_verify_done) begin
               nxt_state = APH_DONE;
               nxt_pass_solid = i_verify_ok;
               nxt_fail_solid = ~i_verify_ok;
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         state_ff <= APH_IDLE;
         pass_solid_ff <= 1'b0;
         fail_solid_ff <= 1'b0;
         fail_blink_ff <= 1'b0;
      end else if (!run_ok) begin
         state_ff <= APH_IDLE;
         pass_solid_ff <= 1'b0;
         fail_solid_ff <= 1'b0;
         fail_blink_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         pass_solid_ff <= nxt_pass_solid;
         fail_solid_ff <= nxt_fail_solid;
         fail_blink_ff <= nxt_fail_blink;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // blink timebase, shared by progress and no-target indications
   // restarted high on every accepted start: a free-running phase could hold
   // the no-target fail low for up to a half-period, which is not "at once"
   logic [CNT_W-1:0] blink_cnt_ff;
   logic blink_ff;
   logic blink_restart;
   assign blink_restart = run_ok && start_edge
      && (state_ff == APH_IDLE || state_ff == APH_DONE);
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b0;
      end else if (blink_restart) begin
         blink_cnt_ff <= '0;
         blink_ff <= 1'b1;
      end else if (blink_cnt_ff == CNT_W'(BLINK_CYCLES - 1)) begin
         blink_cnt_ff <= '0;
         blink_ff <= ~blink_ff;
      end else begin
         blink_cnt_ff <= blink_cnt_ff + 1'b1;
      end
   end

   logic busy;
   assign busy = (state_ff == APH_ERASE) || (state_ff == APH_PROG) || (state_ff == APH_VERIFY);

   ////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         o_in_progress <= 1'b0;
         o_pass <= 1'b0;
         o_fail <= 1'b0;
         o_erase_go <= 1'b0;
         o_prog_go <= 1'b0;
         o_verify_go <= 1'b0;
      end else begin
         o_in_progress <= busy;
         o_pass <= busy ? blink_ff : pass_solid_ff;
         o_fail <= fail_blink_ff ? blink_ff : fail_solid_ff;
         o_erase_go <= (state_ff == APH_ERASE);
         o_prog_go <= (state_ff == APH_PROG);
         o_verify_go <= (state_ff == APH_VERIFY);
      end
   end

   ////////////////////////////////////////////////////////////////////
   active_busy_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      o_in_progress == $past(busy)) else $error("in-progress not tracking run");
   start_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (busy && start_edge) |=> state_ff != APH_IDLE || !run_ok)
      else $error("busy run restarted");
   begin_run_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_IDLE && start_edge && ack_sync_ff && run_ok) |=> state_ff == APH_ERASE)
      else $error("run did not begin");
   pass_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_VERIFY && i_verify_done && i_verify_ok && run_ok) |=> ##1 o_pass)
      else $error("pass not raised");
   clear_flags_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_DONE && start_edge && ack_sync_ff) |=> ##1 (!pass_solid_ff && !o_fail))
      else $error("flags not cleared on new run");
   fail_verify_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_VERIFY && i_verify_done && !i_verify_ok && run_ok) |=> ##1 o_fail)
      else $error("fail not raised");
   no_target_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!busy && start_edge && !ack_sync_ff && run_ok)
      |=> ##1 (!o_in_progress && fail_blink_ff && o_fail))
      else $error("no-target not flagged");
   order_steps_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_PROG) |-> $past(state_ff) inside {APH_ERASE, APH_PROG})
      else $error("program without erase");
   hold_reset_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !run_ok |=> state_ff == APH_IDLE) else $error("sequencer ran in reset");
   verify_end_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (state_ff == APH_VERIFY && i_verify_done && run_ok) |=> ##1 !o_in_progress)
      else $error("in-progress stuck after check");

   // indications follow the shared timebase one edge late
   pass_blink_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      busy |=> o_pass == $past(blink_ff))
      else $error("pass not blinking during run");
   fail_blink_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      fail_blink_ff |=> o_fail == $past(blink_ff))
      else $error("fail not blinking without target");
   steps_onehot_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $onehot0({o_erase_go, o_prog_go, o_verify_go}))
      else $error("two steps running at once");
   // a held or absent request leaves an idle sequencer where it is
   idle_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!busy && !start_edge && run_ok) |=> $stable(state_ff))
      else $error("idle sequencer moved without start edge");
endmodule : aph_seq

/* aph_tgt_model.sv */
`timescale 1ns/1ps
module aph_tgt_model #(
   parameter int unsigned DELAY = 12
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_erase_go,
   input wire logic i_prog_go,
   input wire logic i_verify_go,
   input wire logic i_ok,
   output logic o_erase_done,
   output logic o_prog_done,
   output logic o_verify_done,
   output logic o_verify_ok
);
   logic [2:0] go_ff;
   logic [7:0] cnt_ff;
   logic fire;
   // one done pulse per step; count restarts whenever the step changes
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         go_ff <= 3'h0;
         cnt_ff <= 8'h00;
      end else begin
         go_ff <= {i_erase_go, i_prog_go, i_verify_go};
         cnt_ff <= (go_ff != {i_erase_go, i_prog_go, i_verify_go}) ? 8'h00 : cnt_ff + 8'h01;
      end
   end
   assign fire = (cnt_ff == DELAY[7:0]);
   assign o_erase_done = fire && i_erase_go;
   assign o_prog_done = fire && i_prog_go;
   assign o_verify_done = fire && i_verify_go;
   // result not valid outside its pulse, so show the inverse there
   assign o_verify_ok = o_verify_done ? i_ok : ~i_ok;
endmodule : aph_tgt_model

/* aph_seq_tb_top.sv */
`timescale 1ns/1ps
module aph_seq_tb_top;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic arst_n = 1'b1, start = 1'b0, ack = 1'b1, ok = 1'b1;
   logic e_go, p_go, v_go, in_prog, pass, fail, cpu_rstn, e_dn, p_dn, v_dn, v_ok;
   int miscompares = 0;
   int samples_checked = 0;
   always #25 i_clk_sys = ~i_clk_sys;
   aph_seq #(.BLINK_CYCLES(4)) u_aph_seq (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_automation_reset_n(arst_n), .i_start_req(start), .i_tgt_ack(ack),
      .i_erase_done(e_dn), .i_prog_done(p_dn), .i_verify_done(v_dn), .i_verify_ok(v_ok),
      .o_erase_go(e_go), .o_prog_go(p_go), .o_verify_go(v_go), .o_in_progress(in_prog),
      .o_pass(pass), .o_fail(fail), .o_cpu_rstn(cpu_rstn));
   aph_tgt_model #(.DELAY(12)) u_aph_tgt_model (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
      .i_erase_go(e_go), .i_prog_go(p_go), .i_verify_go(v_go), .i_ok(ok),
      .o_erase_done(e_dn), .o_prog_done(p_dn), .o_verify_done(v_dn), .o_verify_ok(v_ok));
   task automatic chk(input logic got, input logic exp, input string msg);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic no_target;
      int n, hi, lo;
      hi = 0;
      lo = 0;
      @(negedge i_clk_sys);
      ack = 1'b0;
      start = 1'b1;
      for (n = 0; n < 30; n++) begin
         @(negedge i_clk_sys);
         chk(in_prog, 1'b0, "busy without target");
         if (n == 6) chk(fail, 1'b1, "fail late");
         if (fail === 1'b1) hi++;
         if (fail === 1'b0 && n > 6) lo++;
      end
      chk(hi > 0 && lo > 0, 1'b1, "fail not blinking");
      start = 1'b0;
      ack = 1'b1;
      $display("no_target done");
   endtask : no_target
   // poke: drop start then raise it again mid-run; else keep it held throughout
   task automatic do_run(input logic ok_v, input logic poke);
      int n, ce, cp, cv, hi, lo;
      ce = -1;
      cp = -1;
      cv = -1;
      hi = 0;
      lo = 0;
      @(negedge i_clk_sys);
      ok = ok_v;
      // pulse scaled far below the tester's minimum; the sequencer acts on its edge only
      start = 1'b1;
      for (n = 0; n < 6 && in_prog !== 1'b1; n++) @(negedge i_clk_sys);
      chk(in_prog, 1'b1, "run not started");
      chk(fail, 1'b0, "fail not cleared");
      if (poke) start = 1'b0;
      for (n = 0; n < 300 && in_prog === 1'b1; n++) begin
         if (e_go === 1'b1 && ce < 0) ce = n;
         if (p_go === 1'b1 && cp < 0) cp = n;
         if (v_go === 1'b1 && cv < 0) cv = n;
         if (pass === 1'b1) hi++;
         else lo++;
         if (poke && n == 20) start = 1'b1;
         if (poke && n == 24) start = 1'b0;
         @(negedge i_clk_sys);
      end
      chk(ce >= 0 && ce < cp && cp < cv, 1'b1, "step order");
      chk(cv >= 0, 1'b1, "busy dropped early");
      chk(hi > 0 && lo > 0, 1'b1, "pass not blinking");
      for (n = 0; n < 10; n++) begin
         chk(in_prog, 1'b0, "busy after check");
         chk(pass, ok_v, "pass result");
         chk(fail, ~ok_v, "fail result");
         @(negedge i_clk_sys);
      end
      start = 1'b0;
      $display("do_run done");
   endtask : do_run
   task automatic auto_reset;
      int n;
      @(negedge i_clk_sys);
      ok = 1'b1;
      start = 1'b1;
      for (n = 0; n < 6 && in_prog !== 1'b1; n++) @(negedge i_clk_sys);
      start = 1'b0;
      arst_n = 1'b0;
      repeat (4) @(negedge i_clk_sys);
      chk(cpu_rstn, 1'b0, "cpu not held");
      chk(in_prog | pass | fail | e_go, 1'b0, "run not held");
      arst_n = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      chk(cpu_rstn, 1'b1, "cpu still held");
      $display("auto_reset done");
   endtask : auto_reset
   initial begin
      repeat (3) @(negedge i_clk_sys);
      i_rstn = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      no_target();
      do_run(1'b1, 1'b0);
      do_run(1'b0, 1'b1);
      auto_reset();
      stop_test();
   end
   // full run takes well under 1000 cycles
   initial begin
      #(50 * 4000);
      miscompares++;
      stop_test();
   end
endmodule : aph_seq_tb_top
